// ===== core/rus_pkg.sv
/*
 * Shared constants and carrier types for the converter runup sequencer.
 * Assumes a single 125 MHz clock domain and a synchronous active-high reset.
 */
package rus_pkg;

    // ------------------------------------------------------------
    // Counts and lengths, in strobe cycles
    // ------------------------------------------------------------
    localparam int             RUS_BUDGET_W     = 13;
    localparam int             RUS_SLOT_W       = 5;
    localparam int             RUS_RDG_W        = 4;
    localparam int             RUS_RUC_W        = 14;
    localparam logic [8:0]     RUS_COUNTS_FULL  = 9'h13D;  // 317 counts
    localparam logic [8:0]     RUS_COUNTS_SHORT = 9'h022;  // 34 counts
    localparam logic [3:0]     RUS_READINGS     = 4'hA;    // 10 readings
    localparam logic [4:0]     RUS_LEN_60       = 5'h14;   // 20 strobes per count
    localparam logic [4:0]     RUS_LEN_50       = 5'h18;   // 24 strobes per count
    localparam logic [4:0]     RUS_FIRST_60     = 5'h0A;   // 10 strobes
    localparam logic [4:0]     RUS_FIRST_50     = 5'h0C;   // 12 strobes
    localparam logic [4:0]     RUS_GAP_LEN      = 5'h01;   // 1 strobe
    localparam logic [4:0]     RUS_INIT_LEN     = 5'h0A;   // input-only lead-in
    localparam int             RUS_STROBE_DIV   = 8;       // clk cycles per strobe

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RUS_DIG3 = 2'h0,
        RUS_DIG4 = 2'h1,
        RUS_DIG5 = 2'h2
    } rus_mode_e;

    typedef enum logic [4:0] {
        RUS_ST_IDLE  = 5'h01,
        RUS_ST_INPUT = 5'h02,
        RUS_ST_SLOPE = 5'h04,
        RUS_ST_GAP   = 5'h08,
        RUS_ST_WAIT  = 5'h10
    } rus_state_e;

    typedef struct packed {
        rus_mode_e mode;
        logic      hz50;
    } rus_cfg_s;

    typedef struct packed {
        logic input_on;
        logic ref_pos;
        logic ref_neg;
    } rus_sw_s;

endpackage : rus_pkg

// ===== core/rus_strobe_gen.sv
/*
 * Strobe clock generator: divides clk into a strobe pin and a one-cycle tick.
 * Assumes clk is the controller clock; the tick marks each strobe rising edge.
 */
module rus_strobe_gen
    import rus_pkg::*;
#(
    parameter int DIV = RUS_STROBE_DIV
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    output logic      strobe_pin,
    output logic      strobe_tick
);

    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] HALF = CW'(DIV / 2);

    logic [CW-1:0] cnt_q, cnt_d;
    logic          pin_q, pin_d;
    logic          tick_q, tick_d;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    // Tick and pin both registered so the partner sees clean edges
    always_comb begin
        cnt_d  = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        tick_d = (cnt_q == LAST);
        pin_d  = (cnt_d < HALF);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_q  <= '0;
            pin_q  <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            pin_q  <= pin_d;
            tick_q <= tick_d;
        end
    end

    assign strobe_pin  = pin_q;
    assign strobe_tick = tick_q;

endmodule : rus_strobe_gen

// ===== core/rus_runup_seq.sv
/*
 * Runup sequencer of a multi-slope integrating converter: drives the input
 * and reference switches, tracks comparator crossings and the runup count.
 * Assumes the rundown logic sits outside and answers with rundown_done;
 * the comparator arrives asynchronously from the analog side.
 */
// Summary of operation
// R1: Runup lasts 317 counts in the four and five digit modes.
// R2: One count is 20 strobes, or 24 with the 50 Hz option.
// R3: Three digit mode runup uses only 34 counts.
// R4: Five digit mode repeats the conversion for 10 readings.
// R5: The strobe clock timing all slopes is generated here.
// R6: Each conversion runs runup first, then hands over to rundown.
// R7: Runup opens with the input alone, no reference current.
// R8: Input stays connected for the whole runup phase.
// R9: The first reference slope is always the negative one.
// R10: Then opposite polarity for twice the first slope length.
// R11: After a long slope with a crossing, the polarity reverses.
// R12: Without a crossing, the same polarity is applied again.
// R13: Runup counter counts up on positive, down on negative slopes.
// R14: A crossing is a comparator change during the preceding slope.
// R15: A one strobe no-current gap separates successive slopes.
// R16: First negative slope is 10 strobes, or 12 with 50 Hz.
// R17: At runup end, remove references, freeze counter, signal completion.
// R18: Mode and line option are latched at conversion start.
module rus_runup_seq
    import rus_pkg::*;
#(
    parameter int STROBE_DIV = RUS_STROBE_DIV
) (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire logic                          conv_start,
    input  rus_cfg_s                           cfg_in,
    input  wire logic                          integrator_sign_compare,
    input  wire logic                          rundown_done,
    output logic                               strobe_pin,
    output rus_sw_s                            sw_out,
    output logic signed [RUS_RUC_W-1:0]        runup_count,
    output logic                               runup_done,
    output logic                               rundown_active,
    output logic                               conv_done,
    output logic                               busy,
    output logic [RUS_RDG_W-1:0]               reading_idx
);

    localparam logic signed [RUS_RUC_W-1:0] RUC_ONE = 14'sh0001;

    // ------------------------------------------------------------
    // Strobe clock
    // ------------------------------------------------------------
    logic tick;

    // All slope timing advances only on this tick
    rus_strobe_gen #(
        .DIV         (STROBE_DIV)
    ) u_strobe (
        .clk         (clk),
        .sys_rst     (sys_rst),
        .strobe_pin  (strobe_pin),   // R5
        .strobe_tick (tick)          // R5
    );

    // ------------------------------------------------------------
    // Comparator synchroniser
    // ------------------------------------------------------------
    logic cmp_m_q;
    logic cmp_s_q;

    // Two stages; only the second is looked at
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmp_m_q <= 1'b0;
            cmp_s_q <= 1'b0;
        end else begin
            cmp_m_q <= integrator_sign_compare;
            cmp_s_q <= cmp_m_q;
        end
    end

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    rus_state_e                    state_q,  state_d;
    rus_cfg_s                      cfg_q,    cfg_d;
    logic [RUS_BUDGET_W-1:0]       budget_q, budget_d;
    logic [RUS_SLOT_W-1:0]         slot_q,   slot_d;
    logic                          pol_q,    pol_d;
    logic                          first_q,  first_d;
    logic                          cmp0_q,   cmp0_d;
    logic                          cross_q,  cross_d;
    logic signed [RUS_RUC_W-1:0]   ruc_q,    ruc_d;
    logic [RUS_RDG_W-1:0]          rdg_q,    rdg_d;
    logic                          rdone_q,  rdone_d;
    logic                          cdone_q,  cdone_d;
    rus_sw_s                       sw_q,     sw_d;
    logic                          restart;
    logic                          in_runup;
    logic [RUS_SLOT_W-1:0]         long_len;
    logic [RUS_SLOT_W-1:0]         first_len;

    assign in_runup  = (state_q == RUS_ST_INPUT) || (state_q == RUS_ST_SLOPE) ||
                       (state_q == RUS_ST_GAP);
    assign long_len  = cfg_q.hz50 ? RUS_LEN_50 : RUS_LEN_60;         // R2 R10
    assign first_len = cfg_q.hz50 ? RUS_FIRST_50 : RUS_FIRST_60;     // R16

    // Next-state logic; budget counts every strobe of the runup, slot the
    // strobes left in the current slope, gap or lead-in
    always_comb begin
        state_d  = state_q;
        cfg_d    = cfg_q;
        budget_d = budget_q;
        slot_d   = slot_q;
        pol_d    = pol_q;
        first_d  = first_q;
        cmp0_d   = cmp0_q;
        cross_d  = cross_q;
        ruc_d    = ruc_q;
        rdg_d    = rdg_q;
        rdone_d  = 1'b0;
        cdone_d  = 1'b0;
        restart  = 1'b0;
        case (state_q)
            RUS_ST_IDLE: begin
                if (conv_start) begin
                    cfg_d   = cfg_in;                                // R18
                    rdg_d   = '0;
                    restart = 1'b1;
                end
            end
            RUS_ST_INPUT, RUS_ST_SLOPE, RUS_ST_GAP: begin
                if (state_q == RUS_ST_SLOPE && cmp_s_q != cmp0_q) begin
                    cross_d = 1'b1;                                  // R14
                end
                if (tick) begin
                    budget_d = budget_q - 1'b1;
                    if (state_q == RUS_ST_SLOPE) begin
                        ruc_d = pol_q ? ruc_q + RUC_ONE : ruc_q - RUC_ONE;  // R13
                    end
                    if (budget_q == 13'h0001) begin
                        state_d = RUS_ST_WAIT;                       // R17 R6
                        rdone_d = 1'b1;
                    end else if (slot_q != 5'h01) begin
                        slot_d = slot_q - 1'b1;
                    end else if (state_q == RUS_ST_INPUT) begin
                        state_d = RUS_ST_SLOPE;                      // R7
                        slot_d  = first_len;                         // R16
                        pol_d   = 1'b0;                              // R9
                        cmp0_d  = cmp_s_q;
                        cross_d = 1'b0;
                    end else if (state_q == RUS_ST_SLOPE) begin
                        state_d = RUS_ST_GAP;
                        slot_d  = RUS_GAP_LEN;                       // R15
                    end else begin
                        state_d = RUS_ST_SLOPE;
                        slot_d  = long_len;                          // R10
                        // Decision taken after the gap, from the slope before it
                        pol_d   = first_q ? 1'b1 : (pol_q ^ cross_q);  // R11 R12
                        first_d = 1'b0;
                        cmp0_d  = cmp_s_q;
                        cross_d = 1'b0;
                    end
                end
            end
            RUS_ST_WAIT: begin
                if (rundown_done) begin
                    rdg_d = rdg_q + 1'b1;
                    if (cfg_q.mode == RUS_DIG5 && (rdg_q + 1'b1) < RUS_READINGS) begin
                        restart = 1'b1;                              // R4
                    end else begin
                        state_d = RUS_ST_IDLE;
                        cdone_d = 1'b1;
                    end
                end
            end
            default: begin
                state_d = RUS_ST_IDLE;
            end
        endcase
        if (restart) begin
            state_d  = RUS_ST_INPUT;
            slot_d   = RUS_INIT_LEN;
            // Short mode trades resolution for a runup of 34 instead of 317 counts
            budget_d = RUS_BUDGET_W'((cfg_d.mode == RUS_DIG3) ? RUS_COUNTS_SHORT
                                                             : RUS_COUNTS_FULL) *
                       RUS_BUDGET_W'(cfg_d.hz50 ? RUS_LEN_50 : RUS_LEN_60);  // R1 R2 R3
            ruc_d    = '0;
            first_d  = 1'b1;
            cross_d  = 1'b0;
            pol_d    = 1'b0;
        end
        // Switches follow the next state so they line up with state_q
        sw_d.input_on = (state_d == RUS_ST_INPUT) || (state_d == RUS_ST_SLOPE) ||
                        (state_d == RUS_ST_GAP);                     // R8
        sw_d.ref_pos  = (state_d == RUS_ST_SLOPE) && pol_d;
        sw_d.ref_neg  = (state_d == RUS_ST_SLOPE) && !pol_d;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q  <= RUS_ST_IDLE;
            cfg_q    <= '{mode: RUS_DIG4, hz50: 1'b0};
            budget_q <= '0;
            slot_q   <= '0;
            pol_q    <= 1'b0;
            first_q  <= 1'b0;
            cmp0_q   <= 1'b0;
            cross_q  <= 1'b0;
            ruc_q    <= '0;
            rdg_q    <= '0;
            rdone_q  <= 1'b0;
            cdone_q  <= 1'b0;
            sw_q     <= '0;
        end else begin
            state_q  <= state_d;
            cfg_q    <= cfg_d;
            budget_q <= budget_d;
            slot_q   <= slot_d;
            pol_q    <= pol_d;
            first_q  <= first_d;
            cmp0_q   <= cmp0_d;
            cross_q  <= cross_d;
            ruc_q    <= ruc_d;
            rdg_q    <= rdg_d;
            rdone_q  <= rdone_d;
            cdone_q  <= cdone_d;
            sw_q     <= sw_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign sw_out         = sw_q;
    assign runup_count    = ruc_q;
    assign runup_done     = rdone_q;
    assign conv_done      = cdone_q;
    assign rundown_active = (state_q == RUS_ST_WAIT);
    assign busy           = (state_q != RUS_ST_IDLE);
    assign reading_idx    = rdg_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_input_held: assert property (in_runup |-> sw_q.input_on)  // R8
        else $error("input switch open during runup");
    a_lead_no_ref: assert property ((state_q == RUS_ST_INPUT) |-> !sw_q.ref_pos && !sw_q.ref_neg)  // R7
        else $error("reference applied during input lead-in");
    a_first_negative: assert property ((state_q == RUS_ST_SLOPE) && first_q |-> sw_q.ref_neg)  // R9
        else $error("first slope not negative");
    a_first_length: assert property ($rose(state_q == RUS_ST_SLOPE) && first_q |-> slot_q == first_len)  // R16
        else $error("first slope length wrong");
    a_long_length: assert property ($rose(state_q == RUS_ST_SLOPE) && !first_q
                                    |-> slot_q == long_len && $past(state_q) == RUS_ST_GAP)  // R10
        else $error("long slope length wrong");
    a_gap_one: assert property ($rose(state_q == RUS_ST_GAP) |-> slot_q == RUS_GAP_LEN && !sw_q.ref_pos
                                && !sw_q.ref_neg)  // R15
        else $error("gap not one strobe without current");
    a_cross_flip: assert property (tick && state_q == RUS_ST_GAP && slot_q == 5'h01 && budget_q != 13'h0001
                                   && !first_q |=> pol_q == ($past(pol_q) ^ $past(cross_q)))  // R11
        else $error("polarity decision wrong");
    a_count_dir: assert property (tick && state_q == RUS_ST_SLOPE
                                  |=> ruc_q == ($past(pol_q) ? $past(ruc_q) + RUC_ONE : $past(ruc_q) - RUC_ONE))  // R13
        else $error("runup counter direction wrong");
    a_end_frozen: assert property ((state_q == RUS_ST_WAIT) && $past(state_q == RUS_ST_WAIT)
                                   |-> $stable(ruc_q) && sw_q == '0)  // R17
        else $error("activity after runup end");
    a_end_pulse: assert property (runup_done |-> rundown_active && $past(in_runup) ##1 !runup_done)  // R6
        else $error("runup completion pulse wrong");
    a_cfg_hold: assert property (busy && $past(busy) |-> $stable(cfg_q))  // R18
        else $error("config changed mid conversion");
    a_ten_reads: assert property (conv_done && cfg_q.mode == RUS_DIG5 |-> rdg_q == RUS_READINGS)  // R4
        else $error("wrong reading count");
    a_budget_load: assert property ($rose(state_q == RUS_ST_INPUT) |-> budget_q ==
                                    RUS_BUDGET_W'((cfg_q.mode == RUS_DIG3) ? RUS_COUNTS_SHORT : RUS_COUNTS_FULL) *
                                    RUS_BUDGET_W'(cfg_q.hz50 ? RUS_LEN_50 : RUS_LEN_60))  // R1 R2 R3
        else $error("runup budget wrong");

    c_flip: cover property (tick && state_q == RUS_ST_GAP && cross_q && !first_q);
    c_runup_end: cover property (runup_done);
    c_five_digit: cover property (conv_done && cfg_q.mode == RUS_DIG5);
    c_short_50: cover property (conv_done && cfg_q.mode == RUS_DIG3 && cfg_q.hz50);

endmodule : rus_runup_seq

// ===== test/rus_integrator_model.sv
/*
 * Behavioural integrator with reference switches and a sign comparator.
 * Assumes switch controls are active high and settle on the rising clk edge.
 */
module rus_integrator_model
    import rus_pkg::*;
(
    input  wire logic              clk,
    input  rus_sw_s                sw,
    input  wire logic signed [7:0] in_rate,
    output logic                   cmp_out
);
    timeunit 1ns;
    timeprecision 1ps;

    int level = 0;

    // ------------------------------------------------------------
    // Charge balance
    // ------------------------------------------------------------
    // Reference step of 8 exceeds every input rate the bench drives, so every slope can turn
    always @(posedge clk) begin
        level <= level + (sw.input_on ? int'(in_rate) : 0)
                       + (sw.ref_neg ? 8 : 0)  // Negative current, rising output
                       - (sw.ref_pos ? 8 : 0);  // Non-blocking: no race with the synchroniser
    end

    // Comparator follows the sign with no hysteresis
    assign cmp_out = (level > 0);
endmodule : rus_integrator_model

// ===== test/rus_runup_seq_tb.sv
/*
 * Self-checking bench for the runup sequencer with an integrator model.
 * Assumes STROBE_DIV is cut to 2 so full-length runups stay short.
 */
module rus_runup_seq_tb
    import rus_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DIV   = 2;
    localparam int GUARD = 8;  // Comparator sync lag plus strobe slack

    logic                        clk          = 1'b0;
    logic                        sys_rst      = 1'b1;
    logic                        conv_start   = 1'b0;
    rus_cfg_s                    cfg_in       = 3'h2;
    logic                        rundown_done = 1'b0;
    logic signed [7:0]           in_rate      = 8'sh00;
    logic                        sign_cmp;
    logic                        strobe_pin;
    logic                        runup_done;
    logic                        rundown_active;
    logic                        conv_done;
    logic                        busy;
    rus_sw_s                     sw_out;
    logic signed [RUS_RUC_W-1:0] runup_count;
    logic [RUS_RDG_W-1:0]        reading_idx;
    logic                        pin_prev;
    int                          errors       = 0;
    int                          checks_done  = 0;

    rus_runup_seq #(.STROBE_DIV(DIV)) dut (
        .clk                    (clk),
        .sys_rst                (sys_rst),
        .conv_start             (conv_start),
        .cfg_in                 (cfg_in),
        .integrator_sign_compare(sign_cmp),
        .rundown_done           (rundown_done),
        .strobe_pin             (strobe_pin),
        .sw_out                 (sw_out),
        .runup_count            (runup_count),
        .runup_done             (runup_done),
        .rundown_active         (rundown_active),
        .conv_done              (conv_done),
        .busy                   (busy),
        .reading_idx            (reading_idx)
    );

    rus_integrator_model integ (
        .clk    (clk),
        .sw     (sw_out),
        .in_rate(in_rate),
        .cmp_out(sign_cmp)
    );

    initial forever #4 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string msg);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: %s seen %0h want %0h", $time, msg, seen, want);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    // Reset is checked while still held, so a late clear is caught
    task automatic reset_pulse(input int n);
        @(posedge clk) sys_rst <= 1'b1;
        repeat (n) @(posedge clk);
        #1;
        check({busy, sw_out, runup_count, reading_idx, strobe_pin}, '0, "reset state");
        @(posedge clk) sys_rst <= 1'b0;
    endtask : reset_pulse

    // Starts (or follows) one runup and judges every slot on the strobe ticks
    task automatic run_runup(input rus_mode_e mode, input logic hz50, input logic signed [7:0] rate,
                             input bit start, input bit refuse);
        int      len, first, budget, ticks, seg, seg_len, net, cyc, last_rise, t0, last_chg;
        rus_sw_s cur;
        logic    prev_cmp, pol, crossed, amb;
        len    = hz50 ? 24 : 20;
        first  = hz50 ? 12 : 10;
        budget = (mode == RUS_DIG3 ? 34 : 317) * len;
        if (start) begin
            @(posedge clk);
            conv_start <= 1'b1;
            cfg_in     <= '{mode, hz50};
            in_rate    <= rate;
            #1;
            pin_prev = strobe_pin;
            @(posedge clk) conv_start <= 1'b0;
            #1;
        end
        check(busy, 1'b1, "busy at start");
        cur = sw_out; seg = 0; seg_len = 0; ticks = 0; net = 0; last_rise = -1;
        t0 = 0; last_chg = -1000; pol = 1'b0; crossed = 1'b0; amb = 1'b0; prev_cmp = sign_cmp;
        for (cyc = 0; cyc < 40000 && runup_done !== 1'b1; cyc++) begin
            if (sign_cmp !== prev_cmp) begin
                last_chg = cyc;
                if (sw_out.ref_pos || sw_out.ref_neg) crossed = 1'b1;
                if (cyc - t0 < GUARD) amb = 1'b1;
            end
            prev_cmp = sign_cmp;
            if (strobe_pin && !pin_prev) begin
                if (last_rise >= 0) check(cyc - last_rise, DIV, "strobe period");
                last_rise = cyc;
                ticks++;
                check(sw_out.input_on, 1'b1, "input path");
                net += int'(sw_out.ref_pos) - int'(sw_out.ref_neg);
                if (sw_out !== cur) begin
                    case (seg)
                        0: begin
                            check(cur, 3'h4, "lead-in");
                            check(seg_len, RUS_INIT_LEN, "lead-in len");
                        end
                        1: begin
                            check(cur, 3'h5, "first slope");
                            check(seg_len, first, "first len");
                        end
                        3: begin
                            check(cur, 3'h6, "second slope");
                            check(seg_len, len, "second len");
                        end
                        default: begin
                            if (seg % 2 == 0) check({cur, seg_len[3:0]}, 7'h41, "gap");
                            else check(seg_len, len, "slope len");
                        end
                    endcase
                    if (seg % 2 == 1) begin
                        pol = cur.ref_pos;
                        if (cyc - last_chg < GUARD + DIV) amb = 1'b1;
                    end
                    seg++;
                    cur = sw_out;
                    seg_len = 0;
                    if (seg % 2 == 1) begin
                        if (seg >= 5 && !amb) check(sw_out.ref_pos, pol ^ crossed, "polarity");
                        amb     = (cyc - last_chg < GUARD);
                        crossed = 1'b0;
                        t0    = cyc;
                    end
                end
                seg_len++;
            end
            pin_prev = strobe_pin;
            @(posedge clk);
            // Requests that must be ignored while the runup is under way
            if (refuse && cyc == 50) begin
                conv_start   <= 1'b1;
                cfg_in       <= '{RUS_DIG3, 1'b1};
                rundown_done <= 1'b1;
            end
            if (refuse && cyc == 51) begin
                conv_start   <= 1'b0;
                rundown_done <= 1'b0;
            end
            #1;
        end
        if (cyc >= 40000) begin
            errors++;
            finish_test();
        end
        check(ticks, budget, "runup length");
        check(rundown_active, 1'b1, "rundown wait");
        repeat (3) @(posedge clk);
        #1;
        check(sw_out, 3'h0, "refs removed");
        check(runup_count, net, "net count");
    endtask : run_runup

    // Answers the rundown; more is high while further readings must follow
    task automatic end_reading(input logic more);
        @(posedge clk) rundown_done <= 1'b1;
        #1;
        pin_prev = strobe_pin;
        @(posedge clk) rundown_done <= 1'b0;
        #1;
        check(conv_done, !more, "conversion done");
        check(busy, more, "busy after rundown");
    endtask : end_reading

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic scen_dig4_60();
        run_runup(RUS_DIG4, 1'b0, 8'sh03, 1'b1, 1'b1);
        end_reading(1'b0);
    endtask : scen_dig4_60

    task automatic scen_dig4_50();
        run_runup(RUS_DIG4, 1'b1, -8'sh05, 1'b1, 1'b0);
        end_reading(1'b0);
    endtask : scen_dig4_50

    // Zero input, then a large input that forces repeated same-polarity slopes
    task automatic scen_dig3();
        run_runup(RUS_DIG3, 1'b0, 8'sh00, 1'b1, 1'b0);
        end_reading(1'b0);
        run_runup(RUS_DIG3, 1'b1, 8'sh06, 1'b1, 1'b0);
        end_reading(1'b0);
    endtask : scen_dig3

    // Only two readings fit the run; a reset then aborts the conversion
    task automatic scen_dig5();
        run_runup(RUS_DIG5, 1'b0, 8'sh02, 1'b1, 1'b0);
        end_reading(1'b1);
        check(reading_idx, 4'h1, "reading index");
        run_runup(RUS_DIG5, 1'b0, 8'sh02, 1'b0, 1'b0);
        end_reading(1'b1);
        check(reading_idx, 4'h2, "reading index");
        repeat (20) @(posedge clk);
        reset_pulse(2);
    endtask : scen_dig5

    initial begin
        reset_pulse(14);
        scen_dig4_60();
        scen_dig4_50();
        scen_dig3();
        scen_dig5();
        finish_test();
    end
endmodule : rus_runup_seq_tb
